// ---- logic/cucl_down_counter.sv ----
// result-byte down counter with holding-register follow in idle
`default_nettype none
module cucl_down_counter
  import cucl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic running,
  input wire logic step,
  input wire logic [7:0] holding,
  // state
  output logic [7:0] count_r
);
  logic [7:0] count_nxt;

  // idle follows the holding register; running counts alone
  always_comb begin
    count_nxt = count_r;
    if (!running) begin
      count_nxt = holding;
    end else if (step && count_r != CUCL_ZERO_BYTE) begin
      count_nxt = count_r - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= CUCL_RST_BYTE;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule : cucl_down_counter
`default_nettype wire

// ---- logic/cucl_limit_cmp.sv ----
// compare of one byte limit (write limit or zero-extended read limit) against the down counter
`default_nettype none
module cucl_limit_cmp
  import cucl_pkg::*;
(
  // operands
  input wire logic [7:0] count,
  input wire logic [7:0] limit,
  // outcomes
  output logic above,
  output logic reached
);
  // strictly above gates writes; at-or-below holds operand zeroing for the rest
  assign above = count > limit;
  assign reached = count <= limit;
endmodule : cucl_limit_cmp
`default_nettype wire

// ---- logic/cucl_pkg.sv ----
// package: register addresses, field positions, reset values and carriers for cycle/limit control
`default_nettype none
package cucl_pkg;
  // special-function-register addresses on the core's register port
  localparam logic [7:0] CUCL_ADDR_CYCLE_COUNT = 8'hF9;
  localparam logic [7:0] CUCL_ADDR_READ_LIMITS = 8'hFA;
  localparam logic [7:0] CUCL_ADDR_WRITE_LIMIT = 8'hFB;
  localparam logic [7:0] CUCL_ADDR_XOR_OPERAND = 8'hA3;
  localparam logic [7:0] CUCL_ADDR_COMMAND = 8'h99;
  localparam logic [7:0] CUCL_ADDR_CMD_STATUS = 8'h98;
  // reset values
  localparam logic [7:0] CUCL_RST_BYTE = 8'h00;
  localparam logic [7:0] CUCL_ZERO_BYTE = 8'h00;
  // field positions
  localparam int CUCL_CMD_READY_BIT = 0;
  localparam int CUCL_XOR_SEL_BIT = 4;
  localparam int CUCL_STAT_DONE_BIT = 0;
  localparam int CUCL_STAT_RUN_BIT = 2;
  localparam int CUCL_MULT_LIM_HI = 7;
  localparam int CUCL_MULT_LIM_LO = 4;
  localparam int CUCL_ACC_LIM_HI = 3;
  localparam int CUCL_ACC_LIM_LO = 0;

  // sequencer states
  typedef enum logic [1:0] {
    CUCL_IDLE = 2'b01,
    CUCL_RUN = 2'b10
  } cucl_state_t;

  // register-port request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cucl_sfr_req_t;

  // operand bytes from the memory side, one result byte per step
  typedef struct packed {
    logic step;
    logic [7:0] multiplicand_operand;
    logic [7:0] accumulate_operand;
    logic [7:0] result_raw;
  } cucl_dp_in_t;
endpackage : cucl_pkg
`default_nettype wire

// ---- logic/cucl_top.sv ----
// sequencing control: cycle counter, limit registers, result xor and done flag
// Functional notes
// - cycle count writes go to holding register; reads return live counter; reset zero
// - while idle, counter reloads from holding register every clock
// - once started, counter leaves holding register and counts down alone
// - holding register may be rewritten mid-run without touching active count
// - calculation ends as soon as counter reaches zero
// - read limits: upper nibble multiplicand, lower nibble accumulate operand
// - write limit and both zero-extended read limits compared with counter
// - no result write to memory while counter above write limit
// - multiplicand byte forced to zero once counter reached its limit
// - accumulate byte forced to zero once counter reached its limit
// - limit registers read/write, reloadable during a run without effect
// - write and read limit registers reset to zero
// - xor operand register supplies xor input for each result byte while xor select is zero
// - xor operand register resets to zero
// - end of calculation with no start pending sets done flag and raises interrupt request
// - other interrupts held pending while a calculation runs
// - command-ready bit starts calculation; hardware clears it at start
// - xor select zero uses xor register, one uses multiplicand byte
// - counter decrements once per result byte
`default_nettype none
module cucl_top
  import cucl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port from the core
  input wire cucl_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_r,
  // datapath side
  input wire cucl_dp_in_t dp_in,
  output logic [7:0] multiplicand_operand_r,
  output logic [7:0] accumulate_operand_r,
  output logic [7:0] result_output_r,
  output logic result_write_r,
  // status and interrupt
  output logic running_r,
  output logic done_irq_r,
  output logic hold_other_irq_r
);
  cucl_state_t state_r;
  cucl_state_t state_nxt;
  logic [7:0] cycle_hold_r;
  logic [7:0] write_start_limit_r;
  logic [7:0] read_length_limits_r;
  logic [7:0] result_xor_operand_r;
  logic [7:0] command_r;
  logic [7:0] active_cmd_r;
  logic [7:0] active_wlim_r;
  logic [7:0] active_rlim_r;
  logic done_r;
  logic [7:0] count;
  logic [7:0] lim_vec [3];
  logic above [3];
  logic reached [3];
  logic start;
  logic finish;
  logic wr_hit_status;

  // write decode used by every register
  function automatic logic wr_at(input cucl_sfr_req_t r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  assign wr_hit_status = wr_at(sfr_req, CUCL_ADDR_CMD_STATUS);
  assign start = command_r[CUCL_CMD_READY_BIT];
  // end when the live count is zero after a step, or a zero count at start
  assign finish = (state_r == CUCL_RUN) && (count == CUCL_ZERO_BYTE);

  // counter on its own module so the idle follow stays isolated; the finishing
  // cycle reloads it so a chained start begins from the held count, not from zero
  cucl_down_counter u_count (
    .clock(clock),
    .reset(reset),
    .running((state_r == CUCL_RUN) && !finish),
    .step(dp_in.step),
    .holding(cycle_hold_r),
    .count_r(count)
  );

  // read limits zero-extended to a byte before compare; write limit used as is
  assign lim_vec[0] = active_wlim_r;
  assign lim_vec[1] = {4'h0, active_rlim_r[CUCL_MULT_LIM_HI:CUCL_MULT_LIM_LO]};
  assign lim_vec[2] = {4'h0, active_rlim_r[CUCL_ACC_LIM_HI:CUCL_ACC_LIM_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      cucl_limit_cmp u_cmp (
        .count(count),
        .limit(lim_vec[gi]),
        .above(above[gi]),
        .reached(reached[gi])
      );
    end
  endgenerate

  // sequencer: a pending start while running chains straight on
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CUCL_IDLE: begin
        if (start) begin
          state_nxt = CUCL_RUN;
        end
      end
      CUCL_RUN: begin
        if (finish && !start) begin
          state_nxt = CUCL_IDLE;
        end
      end
      default: begin
        state_nxt = CUCL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= CUCL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // holding register for the cycle count; live counter is not disturbed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cycle_hold_r <= CUCL_RST_BYTE;
    end else if (wr_at(sfr_req, CUCL_ADDR_CYCLE_COUNT)) begin
      cycle_hold_r <= sfr_req.wdata;
    end
  end

  // software copies of the limits and xor operand
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_start_limit_r <= CUCL_RST_BYTE;
      read_length_limits_r <= CUCL_RST_BYTE;
      result_xor_operand_r <= CUCL_RST_BYTE;
    end else begin
      if (wr_at(sfr_req, CUCL_ADDR_WRITE_LIMIT)) begin
        write_start_limit_r <= sfr_req.wdata;
      end
      if (wr_at(sfr_req, CUCL_ADDR_READ_LIMITS)) begin
        read_length_limits_r <= sfr_req.wdata;
      end
      if (wr_at(sfr_req, CUCL_ADDR_XOR_OPERAND)) begin
        result_xor_operand_r <= sfr_req.wdata;
      end
    end
  end

  // command register; the ready bit clears as the calculation takes it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      command_r <= CUCL_RST_BYTE;
    end else if (wr_at(sfr_req, CUCL_ADDR_COMMAND)) begin
      command_r <= sfr_req.wdata;
    end else if (start && (state_r == CUCL_IDLE || finish)) begin
      command_r[CUCL_CMD_READY_BIT] <= 1'b0;
    end
  end

  // pipeline copies taken at start so mid-run reloads do not disturb the run
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      active_cmd_r <= CUCL_RST_BYTE;
      active_wlim_r <= CUCL_RST_BYTE;
      active_rlim_r <= CUCL_RST_BYTE;
    end else if (start && (state_r == CUCL_IDLE || finish)) begin
      active_cmd_r <= command_r;
      active_wlim_r <= write_start_limit_r;
      active_rlim_r <= read_length_limits_r;
    end
  end

  // done flag: set wins over a same-cycle software clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
    end else if (finish && !start) begin
      done_r <= 1'b1;
    end else if (wr_hit_status && !sfr_req.wdata[CUCL_STAT_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  // operand forcing and result xor for each byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      multiplicand_operand_r <= CUCL_ZERO_BYTE;
      accumulate_operand_r <= CUCL_ZERO_BYTE;
      result_output_r <= CUCL_ZERO_BYTE;
      result_write_r <= 1'b0;
    end else begin
      multiplicand_operand_r <= (state_r == CUCL_RUN && reached[1])
        ? CUCL_ZERO_BYTE : dp_in.multiplicand_operand;
      accumulate_operand_r <= (state_r == CUCL_RUN && reached[2])
        ? CUCL_ZERO_BYTE : dp_in.accumulate_operand;
      result_output_r <= dp_in.result_raw ^ (active_cmd_r[CUCL_XOR_SEL_BIT]
        ? dp_in.multiplicand_operand : result_xor_operand_r);
      result_write_r <= (state_r == CUCL_RUN) && dp_in.step && !above[0];
    end
  end

  // status and interrupt outputs from flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      running_r <= 1'b0;
      done_irq_r <= 1'b0;
      hold_other_irq_r <= 1'b0;
    end else begin
      running_r <= (state_nxt == CUCL_RUN);
      done_irq_r <= done_r;
      hold_other_irq_r <= (state_nxt == CUCL_RUN);
    end
  end

  // read mux: cycle count reads the live counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sfr_rdata_r <= CUCL_ZERO_BYTE;
    end else if (sfr_req.rd) begin
      if (sfr_req.addr == CUCL_ADDR_CYCLE_COUNT) begin
        sfr_rdata_r <= count;
      end else if (sfr_req.addr == CUCL_ADDR_WRITE_LIMIT) begin
        sfr_rdata_r <= write_start_limit_r;
      end else if (sfr_req.addr == CUCL_ADDR_READ_LIMITS) begin
        sfr_rdata_r <= read_length_limits_r;
      end else if (sfr_req.addr == CUCL_ADDR_XOR_OPERAND) begin
        sfr_rdata_r <= result_xor_operand_r;
      end else if (sfr_req.addr == CUCL_ADDR_COMMAND) begin
        sfr_rdata_r <= command_r;
      end else if (sfr_req.addr == CUCL_ADDR_CMD_STATUS) begin
        sfr_rdata_r <= {5'h00, state_r == CUCL_RUN, 1'b0, done_r};
      end else begin
        sfr_rdata_r <= CUCL_ZERO_BYTE; // unmapped reads as zero
      end
    end
  end
endmodule : cucl_top
`default_nettype wire

// ---- testbench/cucl_dp_model.sv ----
// datapath stand-in: paces result-byte steps and supplies operand bytes
`default_nettype none
module cucl_dp_model
  import cucl_pkg::*;
(
  // clock and status
  input wire logic clock,
  input wire logic reset,
  input wire logic running,
  // operands and step pulses
  output cucl_dp_in_t dp_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pace_r;
  // one step every fourth cycle; idle operand lines toggle so stale values never pass
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pace_r <= 2'h0;
      dp_in <= '0;
    end else begin
      pace_r <= running ? pace_r + 2'h1 : 2'h0;
      dp_in.step <= running && pace_r == 2'h3;
      dp_in.multiplicand_operand <= running ? 8'hA5 : ~dp_in.multiplicand_operand;
      dp_in.accumulate_operand <= running ? 8'h5A : ~dp_in.accumulate_operand;
      dp_in.result_raw <= running ? 8'h3C : ~dp_in.result_raw;
    end
  end
endmodule : cucl_dp_model
`default_nettype wire

// ---- testbench/cucl_top_properties.sv ----
// checker: port-level timing relations of the cycle/limit control
`default_nettype none
module cucl_top_properties
  import cucl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire cucl_sfr_req_t sfr_req,
  input wire cucl_dp_in_t dp_in,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic result_write_r,
  input wire logic running_r,
  input wire logic done_irq_r,
  input wire logic hold_other_irq_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic go;
  logic clr;
  logic unm;
  // decoded core accesses
  assign go = sfr_req.wr && sfr_req.addr == CUCL_ADDR_COMMAND && sfr_req.wdata[0];
  assign clr = sfr_req.wr && sfr_req.addr == CUCL_ADDR_CMD_STATUS && !sfr_req.wdata[0];
  assign unm = sfr_req.rd && !(sfr_req.addr inside {8'hF9, 8'hFA, 8'hFB, 8'hA3, 8'h99, 8'h98});
  sequence s_start;
    go && !running_r;
  endsequence
  property p_start;
    s_start |-> ##2 running_r;
  endproperty
  a_start: assert property (p_start) else $error("run did not start");
  property p_done;
    $fell(running_r) |-> ##[0:2] done_irq_r;
  endproperty
  a_done: assert property (p_done) else $error("done not raised");
  property p_done_stays;
    done_irq_r && !clr && !$past(clr) && !$past(clr, 2) |=> done_irq_r;
  endproperty
  a_done_stays: assert property (p_done_stays) else $error("done dropped");
  property p_rd_unmapped;
    unm |=> sfr_rdata_r == CUCL_ZERO_BYTE;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
  property p_rd_hold;
    !sfr_req.rd |=> $stable(sfr_rdata_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_wr_step;
    result_write_r |-> $past(dp_in.step);
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write without step");
  property p_wr_idle;
    !running_r && !$past(running_r) && !$past(running_r, 2) |-> !result_write_r;
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write while idle");
  property p_hold;
    running_r && $past(running_r) |-> hold_other_irq_r;
  endproperty
  a_hold: assert property (p_hold) else $error("other irqs not held");
endmodule : cucl_top_properties
bind cucl_top cucl_top_properties cucl_top_properties_inst (.clock(clock), .reset(reset),
  .sfr_req(sfr_req), .dp_in(dp_in), .sfr_rdata_r(sfr_rdata_r),
  .result_write_r(result_write_r), .running_r(running_r), .done_irq_r(done_irq_r),
  .hold_other_irq_r(hold_other_irq_r));
`default_nettype wire

// ---- testbench/cucl_top_tb.sv ----
// testbench: register sequences and two calculations through the top block
`default_nettype none
module cucl_top_tb
  import cucl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, wr_p, run, done, hold, step_d;
  cucl_sfr_req_t sfr_req;
  cucl_dp_in_t dp_in;
  logic [7:0] rdata, mop, aop, res, v, first_res, first_m, first_a, last_m, last_a;
  logic [7:0] adr [5] = '{8'hF9, 8'hFA, 8'hFB, 8'hA3, 8'h55};
  int error_cnt = 0, tests_run = 0, cyc = 0, wcnt = 0, nstep = 0;
  cucl_top cucl_top_inst (.clock(clock), .reset(reset), .sfr_req(sfr_req),
    .sfr_rdata_r(rdata), .dp_in(dp_in), .multiplicand_operand_r(mop),
    .accumulate_operand_r(aop), .result_output_r(res), .result_write_r(wr_p),
    .running_r(run), .done_irq_r(done), .hold_other_irq_r(hold));
  cucl_dp_model cucl_dp_model_inst (.clock(clock), .reset(reset), .running(run), .dp_in(dp_in));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1 sfr_req = '{1'b1, 1'b0, a, d};
    @(posedge clock) #1 sfr_req.wr = 0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1 sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) #1 sfr_req.rd = 0;
    d = rdata;
  endtask : rd
  task wait_for(input bit want_done);
    for (int i = 0; i < 200 && (want_done ? done : run) !== 1'b1; i++) @(posedge clock);
    #1;
  endtask : wait_for
  // watchdog, result-write tally and operand capture after each step
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
    end
    if (wr_p === 1'b1) begin
      if (wcnt == 0) first_res = res;
      wcnt++;
    end
    if (step_d === 1'b1) begin
      if (nstep == 0) {first_m, first_a} = {mop, aop};
      {last_m, last_a} = {mop, aop};
      nstep++;
    end
    step_d <= dp_in.step;
  end
  initial begin
    reset = 1;
    sfr_req = '0;
    repeat (2) @(posedge clock);
    #1 reset = 0;
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk(v, CUCL_RST_BYTE);
    end
    wr(CUCL_ADDR_WRITE_LIMIT, 8'hC3);
    rd(CUCL_ADDR_WRITE_LIMIT, v);
    chk(v, 8'hC3);
    wr(CUCL_ADDR_XOR_OPERAND, 8'h0F);
    rd(CUCL_ADDR_XOR_OPERAND, v);
    chk(v, 8'h0F);
    // four bytes, writes from count two, limits two and one
    wr(CUCL_ADDR_CYCLE_COUNT, 8'h04);
    wr(CUCL_ADDR_WRITE_LIMIT, 8'h02);
    wr(CUCL_ADDR_READ_LIMITS, 8'h21);
    wr(CUCL_ADDR_COMMAND, 8'h01);
    wait_for(0);
    rd(CUCL_ADDR_COMMAND, v);
    chk(v & 8'h01, 8'h00);
    wr(CUCL_ADDR_CYCLE_COUNT, 8'h06);
    repeat (2) @(posedge clock);
    rd(CUCL_ADDR_CYCLE_COUNT, v);
    chk({7'h00, v < 8'h04}, 8'h01);
    chk({7'h00, hold}, 8'h01);
    wait_for(1);
    chk({7'h00, wcnt == 2 || wcnt == 3}, 8'h01);
    chk(first_res, 8'h33);
    chk(first_m, 8'hA5);
    chk(first_a, 8'h5A);
    chk(last_m, 8'h00);
    chk(last_a, 8'h00);
    rd(CUCL_ADDR_CMD_STATUS, v);
    chk(v & 8'h05, 8'h01);
    rd(CUCL_ADDR_CYCLE_COUNT, v);
    chk(v, 8'h06);
    wr(CUCL_ADDR_CMD_STATUS, 8'h00);
    repeat (3) @(posedge clock);
    #1 chk({7'h00, done}, 8'h00);
    // six bytes from the held count, every byte written, multiplicand as xor source
    wcnt = 0;
    nstep = 0;
    wr(CUCL_ADDR_WRITE_LIMIT, 8'hFF);
    wr(CUCL_ADDR_READ_LIMITS, 8'h00);
    wr(CUCL_ADDR_COMMAND, 8'h11);
    wait_for(0);
    wait_for(1);
    chk(wcnt[7:0], 8'h06);
    chk(first_res, 8'h99);
    results();
  end
endmodule : cucl_top_tb
`default_nettype wire
